// File: rtl/cnrxb_ctrl.sv
/*
 * Control and status for the high-priority receive buffer: operating mode,
 * acceptance decision, rollover steering, remote-request and filter-hit status.
 * Assumes the host serial decoder presents byte accesses and the assembly
 * buffer presents a one-cycle frame pulse; buffer-full state comes from outside.
 */
// Overview of operation
// R1 - Mode 11: ignore masks and filters, load every received message.
// R2 - Mode 10: accept only valid extended-identifier messages passing a filter.
// R3 - Mode 01: accept only valid standard-identifier messages passing a filter.
// R4 - Bits seven and four read zero; writes there do nothing.
// R5 - Mode 00: accept valid messages of either type per filter setting.
// R6 - Rollover: high buffer full moves new message to low buffer, no overflow.
// R7 - Each accepted message that is stored updates the remote-request status bit.
// R8 - Each accepted message that is stored records hit filter: one when set, zero when clear.
// R9 - Bit one mirrors rollover enable read-only; writes there ignored.
`timescale 1ns/1ps
module cnrxb_ctrl (
    input wire logic clk,
    input wire logic rst_n,
    input wire cnrxb_pkg::cnrxb_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire cnrxb_pkg::cnrxb_frame_t frame,
    input wire logic frame_error,
    input wire logic high_buffer_full,
    output logic load_high,
    output logic load_low,
    output logic overflow,
    output cnrxb_pkg::cnrxb_mode_t rx_operating_mode
);
    cnrxb_pkg::cnrxb_state_t s_q;
    cnrxb_pkg::cnrxb_state_t s_d;
    logic match;
    logic accept;
    logic reg_hit;

    assign reg_hit = reg_req.addr == cnrxb_pkg::RX_BUFFER0_CONTROL_ADDR;

    always_comb begin
        case (s_q.mode)
            cnrxb_pkg::CNRXB_MODE_OFF: match = frame.valid || frame_error; // [R1]
            cnrxb_pkg::CNRXB_MODE_EXT: match = frame.valid && !frame_error && frame.ext_id
                && (frame.hit_filter_zero || frame.hit_filter_one); // [R2]
            cnrxb_pkg::CNRXB_MODE_STD: match = frame.valid && !frame_error && !frame.ext_id
                && (frame.hit_filter_zero || frame.hit_filter_one); // [R3]
            default: match = frame.valid && !frame_error
                && (frame.hit_filter_zero || frame.hit_filter_one); // [R5]
        endcase
    end

    always_comb begin
        accept = match;
        load_high = match && !high_buffer_full;
        load_low = match && high_buffer_full && s_q.rollover_enable; // [R6]
        overflow = match && high_buffer_full && !s_q.rollover_enable; // [R6]
    end

    always_comb begin
        s_d = s_q;
        if (reg_req.wr && reg_hit) begin
            s_d.mode = cnrxb_pkg::cnrxb_mode_t'(reg_req.wdata[cnrxb_pkg::MODE_HI_POS:cnrxb_pkg::MODE_LO_POS]);
            s_d.rollover_enable = reg_req.wdata[cnrxb_pkg::ROLL_POS]; // [R9]
        end
        // Status tracks the message that was stored, high or rolled over
        if (accept && (load_high || load_low)) begin
            s_d.remote_request_received = frame.remote; // [R7]
            s_d.filter_hit_index = frame.hit_filter_one; // [R8]
        end
        // Image captured each cycle, seen one cycle after the address
        if (reg_hit) begin
            s_d.read_image = {1'b0, s_q.mode, 1'b0, s_q.remote_request_received, // [R4]
                              s_q.rollover_enable, s_q.rollover_enable, s_q.filter_hit_index}; // [R9]
        end else begin
            s_d.read_image = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.read_image;
    assign rx_operating_mode = s_q.mode;

    // Mode field must be an adjacent pair inside the byte
    if (cnrxb_pkg::MODE_HI_POS != cnrxb_pkg::MODE_LO_POS + 1 || cnrxb_pkg::MODE_HI_POS > 7) begin : g_layout_check
        $error("Mode field layout does not fit the register");
    end

    property p_r1;
        @(posedge clk) disable iff (!rst_n)
        (s_q.mode == cnrxb_pkg::CNRXB_MODE_OFF && frame.valid && !high_buffer_full) |-> load_high;
    endproperty
    a_r1: assert property (p_r1) else $error("Mode off did not load frame"); // [R1]

    property p_r2;
        @(posedge clk) disable iff (!rst_n)
        (s_q.mode == cnrxb_pkg::CNRXB_MODE_EXT && !frame.ext_id) |-> !(load_high || load_low);
    endproperty
    a_r2: assert property (p_r2) else $error("Standard frame stored in extended mode"); // [R2]

    property p_r3;
        @(posedge clk) disable iff (!rst_n)
        (s_q.mode == cnrxb_pkg::CNRXB_MODE_STD && frame.ext_id) |-> !(load_high || load_low);
    endproperty
    a_r3: assert property (p_r3) else $error("Extended frame stored in standard mode"); // [R3]

    property p_r4;
        @(posedge clk) disable iff (!rst_n)
        ##1 (reg_rdata[7] == 1'b0 && reg_rdata[4] == 1'b0);
    endproperty
    a_r4: assert property (p_r4) else $error("Unimplemented bit read nonzero"); // [R4]

    property p_r5;
        @(posedge clk) disable iff (!rst_n)
        (s_q.mode == cnrxb_pkg::CNRXB_MODE_ALL && frame.valid && !frame_error && frame.hit_filter_zero
            && !high_buffer_full) |-> load_high;
    endproperty
    a_r5: assert property (p_r5) else $error("Valid filtered frame dropped"); // [R5]

    property p_r6;
        @(posedge clk) disable iff (!rst_n)
        (match && high_buffer_full && s_q.rollover_enable) |-> (load_low && !overflow && !load_high);
    endproperty
    a_r6: assert property (p_r6) else $error("Rollover did not steer to low buffer"); // [R6]

    property p_r7;
        @(posedge clk) disable iff (!rst_n)
        (load_high || load_low) |=> (s_q.remote_request_received == $past(frame.remote));
    endproperty
    a_r7: assert property (p_r7) else $error("Remote flag not updated"); // [R7]

    property p_r8;
        @(posedge clk) disable iff (!rst_n)
        (load_high || load_low) |=> (s_q.filter_hit_index == $past(frame.hit_filter_one));
    endproperty
    a_r8: assert property (p_r8) else $error("Filter hit not recorded"); // [R8]

    property p_r9;
        @(posedge clk) disable iff (!rst_n)
        (reg_req.wr && reg_hit) |=> (s_q.rollover_enable == $past(reg_req.wdata[2])) ##1 (reg_rdata[1] == reg_rdata[2]);
    endproperty
    a_r9: assert property (p_r9) else $error("Mirror bit does not track enable"); // [R9]

    property p_r1_error;
        @(posedge clk) disable iff (!rst_n)
        (s_q.mode == cnrxb_pkg::CNRXB_MODE_OFF && frame_error && !high_buffer_full) |-> load_high;
    endproperty
    a_r1_error: assert property (p_r1_error) else $error("Mode off did not load partial frame"); // [R1]

    property p_r1_mode;
        @(posedge clk) disable iff (!rst_n)
        (reg_req.wr && reg_hit) |=> (s_q.mode == $past(reg_req.wdata[6:5]));
    endproperty
    a_r1_mode: assert property (p_r1_mode) else $error("Mode field not written"); // [R1]

    property p_r2_hit;
        @(posedge clk) disable iff (!rst_n)
        (s_q.mode == cnrxb_pkg::CNRXB_MODE_EXT && !frame.hit_filter_zero && !frame.hit_filter_one)
            |-> !(load_high || load_low || overflow);
    endproperty
    a_r2_hit: assert property (p_r2_hit) else $error("Unfiltered frame taken in extended mode"); // [R2]

    property p_r3_hit;
        @(posedge clk) disable iff (!rst_n)
        (s_q.mode == cnrxb_pkg::CNRXB_MODE_STD && !frame.hit_filter_zero && !frame.hit_filter_one)
            |-> !(load_high || load_low || overflow);
    endproperty
    a_r3_hit: assert property (p_r3_hit) else $error("Unfiltered frame taken in standard mode"); // [R3]

    property p_r5_error;
        @(posedge clk) disable iff (!rst_n)
        (s_q.mode == cnrxb_pkg::CNRXB_MODE_ALL && frame_error) |-> !(load_high || load_low || overflow);
    endproperty
    a_r5_error: assert property (p_r5_error) else $error("Errored frame taken in filtered mode"); // [R5]

    property p_r6_full;
        @(posedge clk) disable iff (!rst_n)
        high_buffer_full |-> !load_high;
    endproperty
    a_r6_full: assert property (p_r6_full) else $error("Full high buffer was loaded"); // [R6]

    property p_r6_lost;
        @(posedge clk) disable iff (!rst_n)
        (match && high_buffer_full && !s_q.rollover_enable) |-> (overflow && !load_low);
    endproperty
    a_r6_lost: assert property (p_r6_lost) else $error("Overflow missing without rollover"); // [R6]

    property p_r6_single;
        @(posedge clk) disable iff (!rst_n)
        !((load_high && load_low) || (load_high && overflow) || (load_low && overflow));
    endproperty
    a_r6_single: assert property (p_r6_single) else $error("Two frame outcomes at once"); // [R6]

    property p_r7_hold;
        @(posedge clk) disable iff (!rst_n)
        !(load_high || load_low) |=> $stable(s_q.remote_request_received);
    endproperty
    a_r7_hold: assert property (p_r7_hold) else $error("Remote flag changed without a stored frame"); // [R7]

    property p_r7_read;
        @(posedge clk) disable iff (!rst_n)
        reg_hit |=> (reg_rdata[3] == $past(s_q.remote_request_received));
    endproperty
    a_r7_read: assert property (p_r7_read) else $error("Remote flag read back wrong"); // [R7]

    property p_r8_hold;
        @(posedge clk) disable iff (!rst_n)
        !(load_high || load_low) |=> $stable(s_q.filter_hit_index);
    endproperty
    a_r8_hold: assert property (p_r8_hold) else $error("Filter hit changed without a stored frame"); // [R8]

    property p_r8_read;
        @(posedge clk) disable iff (!rst_n)
        reg_hit |=> (reg_rdata[0] == $past(s_q.filter_hit_index));
    endproperty
    a_r8_read: assert property (p_r8_read) else $error("Filter hit read back wrong"); // [R8]

    property p_r9_read;
        @(posedge clk) disable iff (!rst_n)
        reg_hit |=> (reg_rdata[1] == $past(s_q.rollover_enable));
    endproperty
    a_r9_read: assert property (p_r9_read) else $error("Mirror bit read back wrong"); // [R9]
endmodule

// File: rtl/cnrxb_pkg.sv
/*
 * Package for the high-priority receive buffer control block: register offset,
 * field positions, reset value, mode encodings and carrier structs.
 * Assumes a single 250 MHz clock domain; no imports are used by clients.
 */
package cnrxb_pkg;
    localparam logic [7:0] RX_BUFFER0_CONTROL_ADDR = 8'h60;
    localparam logic [7:0] RX_BUFFER0_CONTROL_RESET = 8'h00;
    localparam int MODE_HI_POS = 6;
    localparam int MODE_LO_POS = 5;
    localparam int RTR_POS = 3;
    localparam int ROLL_POS = 2;
    localparam int MIRROR_POS = 1;
    localparam int HIT_POS = 0;

    typedef enum logic [1:0] {
        CNRXB_MODE_ALL = 2'b00,
        CNRXB_MODE_STD = 2'b01,
        CNRXB_MODE_EXT = 2'b10,
        CNRXB_MODE_OFF = 2'b11
    } cnrxb_mode_t;

    // Host register access, one byte wide
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cnrxb_reg_req_t;

    // Completed frame offered by the message assembly buffer
    typedef struct packed {
        logic valid;
        logic ext_id;
        logic remote;
        logic hit_filter_zero;
        logic hit_filter_one;
    } cnrxb_frame_t;

    typedef struct packed {
        cnrxb_mode_t mode;
        logic remote_request_received;
        logic rollover_enable;
        logic filter_hit_index;
        logic [7:0] read_image;
    } cnrxb_state_t;
endpackage

// File: verif/can_rx_buffer0_control_test.sv
/* Self-checking bench for the high-priority buffer control block.
   Assumes a 250 MHz clock and synchronous active-low reset. */
`timescale 1ns/1ps
module can_rx_buffer0_control_test;
    logic clk, rst_n, frame_error, high_buffer_full, load_high, load_low, overflow;
    logic [7:0] reg_rdata;
    cnrxb_pkg::cnrxb_reg_req_t reg_req;
    cnrxb_pkg::cnrxb_frame_t frame;
    cnrxb_pkg::cnrxb_mode_t rx_operating_mode;
    int fail_count = 0;
    int checks = 0;
    logic [1:0] st = 2'b00;
    logic [11:0] r;
    // Mode, ext, remote, hit zero, hit one, error, full, rollover, then high/low/overflow
    logic [11:0] rows [11] = '{12'h144, 12'h284, 12'h200, 12'h640, 12'h544, 12'h880,
        12'ha84, 12'hc24, 12'h15a, 12'h091, 12'h0a0};
    cnrxb_ctrl u_cnrxb_ctrl (.clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .frame(frame), .frame_error(frame_error), .high_buffer_full(high_buffer_full),
        .load_high(load_high), .load_low(load_low), .overflow(overflow), .rx_operating_mode(rx_operating_mode));
    cnrxb_frame_src u_cnrxb_frame_src (.frame(frame), .frame_error(frame_error));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic final_report;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic reset_check(input int n);
        rst_n <= 1'b0;
        repeat (n) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1 check("reset image", reg_rdata, cnrxb_pkg::RX_BUFFER0_CONTROL_RESET);
        $display("reset test done");
    endtask
    initial begin
        #100000 fail_count++;
        final_report();
    end
    initial begin
        reg_req <= {1'b0, cnrxb_pkg::RX_BUFFER0_CONTROL_ADDR, 8'h00};
        high_buffer_full <= 1'b0;
        reset_check(4);
        foreach (rows[i]) begin
            r = rows[i];
            @(posedge clk);
            // Ones in bits 7, 4, 3, 1, 0 must be ignored
            reg_req <= {1'b1, 8'h60, 1'b1, r[11:10], 2'b11, r[3], 2'b11};
            high_buffer_full <= r[4];
            @(posedge clk);
            reg_req.wr <= 1'b0;
            u_cnrxb_frame_src.send({1'b1, r[9:6]}, r[5]);
            #1 check("loads", {3'h0, rx_operating_mode, load_high, load_low, overflow}, {3'h0, r[11:10], r[2:0]});
            if (r[2:1] != 2'b00) st = {r[8], r[6]};
            @(posedge clk);
            u_cnrxb_frame_src.send('0, 1'b0);
            repeat (2) @(posedge clk);
            #1 check("image", reg_rdata, {1'b0, r[11:10], 1'b0, st[1], r[3], r[3], st[0]});
            $display("row %0d done", i);
        end
        @(posedge clk);
        // Partial frame in filters-off mode rolls over to the low buffer
        reg_req <= {1'b1, cnrxb_pkg::RX_BUFFER0_CONTROL_ADDR, 8'h64};
        high_buffer_full <= 1'b1;
        @(posedge clk);
        reg_req.wr <= 1'b0;
        u_cnrxb_frame_src.send(5'h04, 1'b1);
        #1 check("partial loads", {3'h0, rx_operating_mode, load_high, load_low, overflow}, 8'h1a);
        @(posedge clk);
        u_cnrxb_frame_src.send(5'h00, 1'b0);
        repeat (2) @(posedge clk);
        #1 check("partial image", reg_rdata, 8'h6e);
        $display("partial frame test done");
        @(posedge clk);
        reset_check(1);
        final_report();
    end
endmodule

// File: verif/cnrxb_frame_src.sv
/* Far-side model: hands completed frames from assembly to the control block.
   Assumes the caller invokes send just after a rising clock edge. */
`timescale 1ns/1ps
module cnrxb_frame_src (
    output cnrxb_pkg::cnrxb_frame_t frame,
    output logic frame_error
);
    initial begin
        frame = '0;
        frame_error = 1'b0;
    end
    task automatic send(input logic [4:0] f, input logic e);
        frame <= f;
        frame_error <= e;
    endtask
endmodule
